// File: logic/half_bridge_fault_protection.sv
// Fault protection and serial control for three half-bridges
// What this block does
// - Both drivers of one channel requested on: force both off, set bit 12
// - Shoot-through flag holds until a frame carries the status-reset bit
// - While shoot-through flag is set, that channel's drivers stay off
// - Overcurrent detect on a driver starts its shutdown timer
// - Overcurrent lasting the whole delay latches the driver off
// - Overcurrent shutdown sets status bit 13 until status reset
// - Overcurrent latch releases only on a frame with status-reset bit set
// - Control bit 13 picks delay: 1 gives 25 us, 0 gives 200 us
// - Changing delay select does not alter a running overcurrent delay
// - No driver turns on while over-temperature shutdown is active
// - Underload is only judged on drivers commanded on
// - Underload lasting beyond the delay sets status bit 14
// - Control bit 14 set: underload fault latches driver off
// - One global underload timer; later underloads expire with it
// - Global timer keeps running while any underload persists
// - Underload flag clears only on status-reset bit 0 received as 1
// - Underload-latched driver stays off until status reset
// - Status shifts out on serial output while control shifts in
//
// Chosen here: the APB register port and the placing of the registers.
module half_bridge_fault_protection #(
  parameter int OC_SHORT = hbp_pkg::OC_SHORT_CYCLES,
  parameter int OC_LONG = hbp_pkg::OC_LONG_CYCLES,
  parameter int UL_DELAY = hbp_pkg::UL_DELAY_CYCLES
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  input wire logic [5:0] overcurrent_detect,
  input wire logic [5:0] underload_detect,
  input wire logic over_temp_shutdown,
  input wire logic thermal_warning,
  input wire logic supply_fail,
  output logic [5:0] half_bridge_output,
  output logic irq,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  // Timer width; every delay in cycles must fit a counter this wide
  localparam int TW = 16;

  // ==========================================================
  // Elaboration checks: refuse delays the timers cannot count
  if (OC_SHORT < 1 || OC_SHORT >= 2 ** TW) begin : g_bad_short
    $error("OC_SHORT does not fit the timers");
  end
  if (OC_LONG < 1 || OC_LONG >= 2 ** TW) begin : g_bad_long
    $error("OC_LONG does not fit the timers");
  end
  if (UL_DELAY < 1 || UL_DELAY >= 2 ** TW) begin : g_bad_underload
    $error("UL_DELAY does not fit the timers");
  end

  // Two-stage synchronisers for every pin from outside the clock domain
  typedef struct packed {
    logic [1:0] rst_sync;
    logic [1:0] sclk_s;
    logic [1:0] cs_s;
    logic [1:0] si_s;
    logic [5:0] oc_s1;
    logic [5:0] oc_s;
    logic [5:0] ul_s1;
    logic [5:0] ul_s;
    logic [1:0] ot_s;
    logic [1:0] tw_s;
    logic [1:0] sf_s;
  } sync_state_t;

  // Protection and bus state, kept on the released reset copy
  typedef struct packed {
    logic [15:0] control;
    logic [2:0] shoot_through_flag;
    logic overcurrent_status_flag;
    logic underload_status_flag;
    logic thermal_flag;
    logic supply_flag;
    logic [5:0] oc_latch;
    logic [5:0] ul_latch;
    logic [5:0] drive;
    logic [3:0] irq_status;
    logic [3:0] irq_mask;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } core_state_t;

  // Registered state and the wires between frame port, timers and core
  sync_state_t sync;
  sync_state_t next_sync;
  core_state_t state;
  core_state_t next_state;
  logic rst_n;
  logic [15:0] status_word;
  logic [15:0] frame_word;
  logic frame_done;
  logic [5:0] oc_expired;
  logic ul_expired;
  logic [TW-1:0] oc_length;
  logic [5:0] commanded;
  logic [5:0] ul_active;

  // ==========================================================
  // Decode helpers
  // Access-phase write to one offset; it lands on the edge that sees ready
  function automatic logic write_hit(
    input logic sel,
    input logic enable,
    input logic write,
    input logic [11:0] addr,
    input logic [11:0] target
  );
    return sel && enable && write && (addr == target);
  endfunction

  // Channel c owns driver 2c (low side) and driver 2c+1 (high side)
  function automatic logic [5:0] channel_pair(input int c);
    logic [5:0] pair;
    pair = 6'h00;
    pair[2 * c] = 1'b1;
    pair[2 * c + 1] = 1'b1;
    return pair;
  endfunction

  // ==========================================================
  // Reset release and pin synchronisers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sync <= '{rst_sync: 2'b00, sclk_s: 2'b00, cs_s: 2'b11, si_s: 2'b00,
                oc_s1: 6'h00, oc_s: 6'h00, ul_s1: 6'h00, ul_s: 6'h00,
                ot_s: 2'b00, tw_s: 2'b00, sf_s: 2'b00};
    end else begin
      sync <= next_sync;
    end
  end

  always_comb begin
    next_sync = sync;
    next_sync.rst_sync = {sync.rst_sync[0], 1'b1};
    next_sync.sclk_s = {sync.sclk_s[0], sclk};
    next_sync.cs_s = {sync.cs_s[0], cs_n};
    next_sync.si_s = {sync.si_s[0], si};
    next_sync.oc_s1 = overcurrent_detect;
    next_sync.oc_s = sync.oc_s1;
    next_sync.ul_s1 = underload_detect;
    next_sync.ul_s = sync.ul_s1;
    next_sync.ot_s = {sync.ot_s[0], over_temp_shutdown};
    next_sync.tw_s = {sync.tw_s[0], thermal_warning};
    next_sync.sf_s = {sync.sf_s[0], supply_fail};
  end

  // Internal reset asserts at once and releases two edges later
  assign rst_n = sync.rst_sync[1];

  // ==========================================================
  // Status word sent during the next frame
  always_comb begin
    status_word = 16'h0000;
    status_word[hbp_pkg::BIT_SUPPLY_FAIL] = state.supply_flag;
    status_word[hbp_pkg::BIT_UNDERLOAD] = state.underload_status_flag;
    status_word[hbp_pkg::BIT_OVERCURRENT] = state.overcurrent_status_flag;
    status_word[hbp_pkg::BIT_SHOOT_THROUGH] = |state.shoot_through_flag;
    status_word[6:1] = state.drive;
    status_word[0] = state.thermal_flag;
  end

  // Frame port runs on the synchronised pin copies only
  serial_frame #(
    .WIDTH(TW)
  ) u_frame (
    .clock(clock),
    .rst_n(rst_n),
    .sclk_sync(sync.sclk_s[1]),
    .cs_n_sync(sync.cs_s[1]),
    .si_sync(sync.si_s[1]),
    .status_word(status_word),
    .so(so),
    .frame_word(frame_word),
    .frame_done(frame_done)
  );

  // ==========================================================
  // Overcurrent delay chosen when each timer starts
  assign oc_length = state.control[hbp_pkg::BIT_OC_DELAY_SELECT]
                   ? TW'(OC_SHORT) : TW'(OC_LONG);

  // One timer per driver, so each keeps its own start and length
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_oc
      fault_timer #(
        .WIDTH(TW)
      ) u_oc (
        .clock(clock),
        .rst_n(rst_n),
        .run(sync.oc_s[g] && state.drive[g] && !state.oc_latch[g]),
        .length(oc_length),
        .expired(oc_expired[g])
      );
    end
  endgenerate

  // Underload only counts on commanded-on drivers
  assign commanded = state.control[6:1];
  assign ul_active = sync.ul_s & commanded & state.drive;

  // One timer for all channels, running while any underload lasts
  fault_timer #(
    .WIDTH(TW)
  ) u_ul (
    .clock(clock),
    .rst_n(rst_n),
    .run(|ul_active),
    .length(TW'(UL_DELAY)),
    .expired(ul_expired)
  );

  // ==========================================================
  // Flags, latches, drive and bus slave
  always_comb begin
    logic clear;
    logic [15:0] word;
    logic [2:0] attempt;
    logic [5:0] ul_hit;
    logic [5:0] allowed;
    logic [3:0] events;
    clear = frame_done && frame_word[hbp_pkg::BIT_STATUS_RESET];
    word = frame_word;
    attempt = 3'b000;
    ul_hit = ul_active & {6{ul_expired}};
    events = 4'h0;
    allowed = 6'h00;
    next_state = state;
    next_state.pready = 1'b0;
    next_state.pslverr = 1'b0;
    // A complete frame replaces the whole control word
    if (frame_done) begin
      next_state.control = word;
      events[hbp_pkg::EV_FRAME] = 1'b1;
    end
    // Status reset first so a same-cycle fault still wins
    if (clear) begin
      next_state.shoot_through_flag = 3'b000;
      next_state.overcurrent_status_flag = 1'b0;
      next_state.underload_status_flag = 1'b0;
      next_state.oc_latch = 6'h00;
      next_state.ul_latch = 6'h00;
      next_state.thermal_flag = 1'b0;
      next_state.supply_flag = 1'b0;
    end
    // Both sides of one channel requested in the same frame
    for (int c = 0; c < 3; c++) begin
      attempt[c] = frame_done && ((word[6:1] & channel_pair(c)) == channel_pair(c));
    end
    if (attempt != 3'b000) begin
      next_state.shoot_through_flag = next_state.shoot_through_flag | attempt;
      events[hbp_pkg::EV_SHOOT] = 1'b1;
    end
    // Each expired overcurrent timer latches its own driver
    if (oc_expired != 6'h00) begin
      next_state.oc_latch = next_state.oc_latch | oc_expired;
      next_state.overcurrent_status_flag = 1'b1;
      events[hbp_pkg::EV_OVERCURRENT] = 1'b1;
    end
    // Underload always reports; it latches only when shutdown is enabled
    if (ul_hit != 6'h00) begin
      next_state.underload_status_flag = 1'b1;
      events[hbp_pkg::EV_UNDERLOAD] = 1'b1;
      if (state.control[hbp_pkg::BIT_UL_SHUTDOWN_ENABLE]) begin
        next_state.ul_latch = next_state.ul_latch | ul_hit;
      end
    end
    // Warning and supply flags stay set until a status reset
    if (sync.tw_s[1]) begin
      next_state.thermal_flag = 1'b1;
    end
    if (sync.sf_s[1]) begin
      next_state.supply_flag = 1'b1;
    end
    // Gate each driver by its own faults and its channel's flag
    allowed = ~(next_state.oc_latch | next_state.ul_latch);
    for (int c = 0; c < 3; c++) begin
      if (next_state.shoot_through_flag[c]) begin
        allowed = allowed & ~channel_pair(c);
      end
    end
    // Over-temperature overrides every request while it lasts
    if (sync.ot_s[1]) begin
      allowed = 6'h00;
    end
    next_state.drive = next_state.control[6:1] & allowed;
    // Interrupt: set beats write-one-to-clear
    if (write_hit(psel, penable, pwrite, paddr, hbp_pkg::ADDR_STATUS)) begin
      next_state.irq_status = state.irq_status & ~pwdata[3:0];
    end
    next_state.irq_status = next_state.irq_status | events;
    if (write_hit(psel, penable, pwrite, paddr, hbp_pkg::ADDR_MASK)) begin
      next_state.irq_mask = pwdata[3:0];
    end
    next_state.irq = |(next_state.irq_status & next_state.irq_mask);
    // APB: answer in the access cycle's next edge, zero wait states
    if (psel && !penable) begin
      next_state.pready = 1'b1;
      next_state.prdata = 32'h0000_0000;
      // Unmapped offsets answer with an error and zero data
      case (paddr)
        hbp_pkg::ADDR_STATUS: next_state.prdata = {28'h0000000, state.irq_status};
        hbp_pkg::ADDR_MASK: next_state.prdata = {28'h0000000, state.irq_mask};
        hbp_pkg::ADDR_CONTROL: next_state.prdata = {16'h0000, state.control};
        hbp_pkg::ADDR_FAULT: begin
          next_state.prdata = {4'h0, state.ul_latch, state.oc_latch, status_word};
        end
        default: next_state.pslverr = 1'b1;
      endcase
    end
  end

  // Core registers; reset comes from the synchronised copy
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= '{control: hbp_pkg::CONTROL_RESET, shoot_through_flag: 3'b000,
                 overcurrent_status_flag: 1'b0, underload_status_flag: 1'b0,
                 thermal_flag: 1'b0, supply_flag: 1'b0, oc_latch: 6'h00,
                 ul_latch: 6'h00, drive: 6'h00, irq_status: 4'h0, irq_mask: 4'h0,
                 irq: 1'b0, prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Outputs, each straight from a flip-flop
  assign half_bridge_output = state.drive;
  assign irq = state.irq;
  assign prdata = state.prdata;
  assign pready = state.pready;
  assign pslverr = state.pslverr;
endmodule

// File: logic/hbp_pkg.sv
// Shared constants for the half-bridge fault protection block
package hbp_pkg;
  // ==========================================================
  // Frame layout
  localparam int FRAME_BITS = 16;
  localparam int CHANNELS = 3;
  localparam int DRIVERS = 6;
  localparam int BIT_STATUS_RESET = 0;
  localparam int BIT_DRIVER_LSB = 1;
  localparam int BIT_SHOOT_THROUGH = 12;
  localparam int BIT_OC_DELAY_SELECT = 13;
  localparam int BIT_OVERCURRENT = 13;
  localparam int BIT_UL_SHUTDOWN_ENABLE = 14;
  localparam int BIT_UNDERLOAD = 14;
  localparam int BIT_SUPPLY_FAIL = 15;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  // ==========================================================
  // Timing
  localparam int CLOCK_MHZ = 100;
  localparam int OC_SHORT_US = 25;
  localparam int OC_LONG_US = 200;
  localparam int UL_DELAY_US = 200;
  localparam int OC_SHORT_CYCLES = OC_SHORT_US * CLOCK_MHZ;
  localparam int OC_LONG_CYCLES = OC_LONG_US * CLOCK_MHZ;
  localparam int UL_DELAY_CYCLES = UL_DELAY_US * CLOCK_MHZ;
  // ==========================================================
  // Frame and fault interrupt events
  localparam int EVENTS = 4;
  localparam int EV_FRAME = 0;
  localparam int EV_SHOOT = 1;
  localparam int EV_OVERCURRENT = 2;
  localparam int EV_UNDERLOAD = 3;
  // ==========================================================
  // Register bus byte offsets
  localparam logic [11:0] ADDR_STATUS = 12'h000;
  localparam logic [11:0] ADDR_MASK = 12'h004;
  localparam logic [11:0] ADDR_CONTROL = 12'h008;
  localparam logic [11:0] ADDR_FAULT = 12'h00C;
endpackage

// File: logic/serial_frame.sv
// Serial shift port: takes the control word in, shifts status out
module serial_frame #(
  parameter int WIDTH = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic sclk_sync,
  input wire logic cs_n_sync,
  input wire logic si_sync,
  input wire logic [WIDTH-1:0] status_word,
  output logic so,
  output logic [WIDTH-1:0] frame_word,
  output logic frame_done
);
  // Elaboration check: the shifter needs at least two bits
  if (WIDTH < 2) begin : g_bad_width
    $error("WIDTH too small");
  end

  typedef struct packed {
    logic sclk_prev;
    logic cs_prev;
    logic [WIDTH-1:0] shift;
    logic [15:0] count;
    logic so;
    logic [WIDTH-1:0] word;
    logic done;
  } frame_state_t;

  frame_state_t state;
  frame_state_t next_state;

  // ==========================================================
  // Mode 0: sample on rising sclk, shift out on falling
  always_comb begin
    next_state = state;
    next_state.sclk_prev = sclk_sync;
    next_state.cs_prev = cs_n_sync;
    next_state.done = 1'b0;
    if (state.cs_prev && !cs_n_sync) begin
      // Frame start: load status, MSB appears at once
      next_state.shift = status_word;
      next_state.so = status_word[WIDTH-1];
      next_state.count = 16'h0000;
    end else if (!cs_n_sync && sclk_sync && !state.sclk_prev) begin
      next_state.shift = {state.shift[WIDTH-2:0], si_sync};
      if (state.count != 16'hFFFF) begin
        next_state.count = state.count + 16'h0001;
      end
    end else if (!cs_n_sync && !sclk_sync && state.sclk_prev) begin
      next_state.so = state.shift[WIDTH-1];
    end
    // Short frames are ignored, long ones keep the last word in
    if (!state.cs_prev && cs_n_sync) begin
      if (32'(state.count) >= WIDTH) begin
        next_state.word = state.shift;
        next_state.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= '{sclk_prev: 1'b0, cs_prev: 1'b1, shift: '0, count: 16'h0000,
                 so: 1'b0, word: '0, done: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  assign so = state.so;
  assign frame_word = state.word;
  assign frame_done = state.done;
endmodule

// File: logic/fault_timer.sv
// Down-counter for a fault delay, loaded with its length at start
module fault_timer #(
  parameter int WIDTH = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [WIDTH-1:0] length,
  output logic expired
);
  // Elaboration check: a one-bit counter cannot hold a delay
  if (WIDTH < 2) begin : g_bad_width
    $error("WIDTH too small");
  end

  typedef struct packed {
    logic active;
    logic [WIDTH-1:0] left;
  } timer_state_t;

  timer_state_t state;
  timer_state_t next_state;

  // ==========================================================
  // Length captured at start only, so later changes do nothing
  always_comb begin
    next_state = state;
    if (!run) begin
      next_state.active = 1'b0;
      next_state.left = '0;
    end else if (!state.active) begin
      next_state.active = 1'b1;
      next_state.left = length;
    end else if (state.left != '0) begin
      next_state.left = state.left - WIDTH'(1);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= '{active: 1'b0, left: '0};
    end else begin
      state <= next_state;
    end
  end

  assign expired = state.active && (state.left == '0);
endmodule

// File: tb/hbp_host.sv
// Serial host model that frames control words into the block
module hbp_host (
  output logic sclk,
  output logic cs_n,
  output logic si,
  input wire logic so
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================
  // Idle lines
  // Clock stands low between frames; input line is driven low
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end

  // ==========================================
  // Frame
  // Mode 0: data set while clock low, status taken on the rising edge
  task automatic frame(input logic [15:0] w, output logic [15:0] r);
    #3 cs_n = 1'b0;
    #500;
    for (int i = 15; i >= 0; i--) begin
      si = w[i];
      #62.5 sclk = 1'b1;
      r[i] = so;
      #62.5 sclk = 1'b0;
    end
    #100 cs_n = 1'b1;
    si = 1'b0;
    // Gap well above the minimum so the frame has been applied
    #250;
  endtask
endmodule

// File: tb/hbp_properties.sv
// Concurrent checks on the fault-protection top ports
module hbp_properties #(
  parameter int OC_LONG = 20000
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [5:0] overcurrent_detect,
  input wire logic [5:0] underload_detect,
  input wire logic over_temp_shutdown,
  input wire logic [5:0] half_bridge_output
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================
  // Overcurrent dwell
  int oc_cnt;
  // Cycles a driver has stayed on into an overcurrent
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      oc_cnt <= 0;
    end else if (|(half_bridge_output & overcurrent_detect)) begin
      oc_cnt <= oc_cnt + 1;
    end else begin
      oc_cnt <= 0;
    end
  end

  // ==========================================
  // Properties
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence apb_done;
    psel && penable && pready;
  endsequence
  // Eight cycles covers the apply latency after a chip-select rise
  sequence quiet;
    !cs_n && overcurrent_detect == 6'h00 && underload_detect == 6'h00 && !over_temp_shutdown;
  endsequence
  a_pair_never_on: assert property (
    (half_bridge_output & (half_bridge_output >> 1) & 6'h15) == 6'h00)
    else $error("both drivers of a channel on");
  a_hot_keeps_off: assert property (
    over_temp_shutdown [*4] |-> (half_bridge_output & ~$past(half_bridge_output)) == 6'h00)
    else $error("driver turned on while too hot");
  a_oc_dwell_bound: assert property (
    oc_cnt <= OC_LONG + 10)
    else $error("overcurrent outlasted the long delay");
  a_frame_outputs_hold: assert property (
    quiet [*8] |-> $stable(half_bridge_output))
    else $error("drivers changed inside a quiet frame");
  a_apb_answer: assert property (
    apb_setup ##1 (psel && penable) |-> pready)
    else $error("no ready in access cycle");
  a_ready_pulse: assert property (
    pready |=> !pready)
    else $error("ready held too long");
  a_unmapped_error: assert property (
    apb_done ##0 (paddr > 12'h00C) |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (
    apb_done ##0 (paddr <= 12'h00C && paddr[1:0] == 2'h0) |-> !pslverr)
    else $error("mapped access refused");
endmodule

bind half_bridge_fault_protection hbp_properties #(.OC_LONG(OC_LONG)) props (
  .clock(clock),
  .reset_n(reset_n),
  .cs_n(cs_n),
  .psel(psel),
  .penable(penable),
  .paddr(paddr),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .overcurrent_detect(overcurrent_detect),
  .underload_detect(underload_detect),
  .over_temp_shutdown(over_temp_shutdown),
  .half_bridge_output(half_bridge_output)
);

// File: tb/half_bridge_fault_protection_tb.sv
// Self-checking bench for the half-bridge fault protection block
module half_bridge_fault_protection_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // Shortened delays keep frames and timers in one run
  localparam int OCS = 300;
  localparam int OCL = 1200;
  localparam int ULD = 1000;
  logic clock, reset_n, psel, penable, pwrite, pready, pslverr, irq, er;
  logic sclk, cs_n, si, so, ot;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0] overcurrent_delay_select, uld, hbo;
  logic [15:0] st;
  int mismatches, n_checks;

  half_bridge_fault_protection #(.OC_SHORT(OCS), .OC_LONG(OCL), .UL_DELAY(ULD)) dut (
    .clock(clock), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n), .si(si), .so(so),
    .overcurrent_detect(overcurrent_delay_select), .underload_detect(uld), .over_temp_shutdown(ot),
    .thermal_warning(1'b0), .supply_fail(1'b0), .half_bridge_output(hbo), .irq(irq),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  hbp_host host (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so));

  // ==========================================
  // Clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ==========================================
  // Helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Holds the request until ready is seen, then releases
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(16'(pready), 16'h0001, "apb ready");
  endtask
  function automatic logic [15:0] ctl(logic ul, logic oc, logic [5:0] drv, logic status_reset_bit);
    return {1'b0, ul, oc, 6'h00, drv, status_reset_bit};
  endfunction
  task automatic fr(input logic [15:0] w);
    host.frame(w, st);
    cyc(2);
  endtask

  // ==========================================
  // Scenarios
  task automatic t_regs;
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk(rd[15:0], 16'h0000, "mask reset");
    apb(1'b1, 12'h004, 32'h0000_0002);
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk(rd[15:0], 16'h0002, "mask rw");
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk(16'(er), 16'h0001, "unmapped err");
  endtask
  task automatic t_shoot;
    fr(ctl(1'b0, 1'b0, 6'h03, 1'b0));
    chk(16'(hbo), 16'h0000, "pair forced off");
    chk(16'(irq), 16'h0001, "irq raised");
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk(rd[15:0], 16'h0006, "control readback");
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk(rd[15:0], 16'h1000, "fault word");
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk(16'(rd[1]), 16'h0001, "irq status");
    apb(1'b1, 12'h000, 32'h0000_0002);
    cyc(2);
    chk(16'(irq), 16'h0000, "irq cleared, frame masked");
    fr(ctl(1'b0, 1'b0, 6'h01, 1'b0));
    chk(16'(st[12]), 16'h0001, "shoot flag");
    chk(16'(hbo), 16'h0000, "held off");
    fr(ctl(1'b0, 1'b0, 6'h01, 1'b1));
    chk(16'(st[12]), 16'h0001, "shoot flag kept");
    chk(16'(hbo), 16'h0001, "released");
    fr(ctl(1'b0, 1'b0, 6'h01, 1'b0));
    chk(16'(st[12]), 16'h0000, "shoot flag cleared");
    chk(16'(st[6:1]), 16'h0001, "driver state out");
  endtask
  task automatic t_ovc;
    fr(ctl(1'b0, 1'b1, 6'h01, 1'b1));
    overcurrent_delay_select <= 6'h01;
    cyc(OCS - 20);
    chk(16'(hbo), 16'h0001, "short delay not yet");
    cyc(40);
    chk(16'(hbo), 16'h0000, "short delay off");
    fr(ctl(1'b0, 1'b0, 6'h01, 1'b0));
    chk(16'(st[13]), 16'h0001, "oc flag");
    chk(16'(hbo), 16'h0000, "oc latched");
    overcurrent_delay_select <= 6'h00;
    fr(ctl(1'b0, 1'b0, 6'h01, 1'b1));
    chk(16'(hbo), 16'h0001, "oc released");
    overcurrent_delay_select <= 6'h01;
    fr(ctl(1'b0, 1'b1, 6'h01, 1'b0));
    chk(16'(st[13]), 16'h0000, "oc flag cleared");
    cyc(OCS);
    chk(16'(hbo), 16'h0001, "running long delay kept");
    cyc(OCL - 620);
    chk(16'(hbo), 16'h0001, "long delay not yet");
    cyc(60);
    chk(16'(hbo), 16'h0000, "long delay off");
    overcurrent_delay_select <= 6'h00;
    fr(ctl(1'b0, 1'b0, 6'h00, 1'b1));
  endtask
  task automatic t_temp;
    ot <= 1'b1;
    fr(ctl(1'b0, 1'b0, 6'h02, 1'b0));
    chk(16'(hbo), 16'h0000, "hot refuse");
    ot <= 1'b0;
    cyc(10);
    chk(16'(hbo), 16'h0002, "cool on");
  endtask
  task automatic t_uld;
    fr(ctl(1'b0, 1'b0, 6'h01, 1'b1));
    uld <= 6'h06;
    cyc(ULD + 20);
    fr(ctl(1'b0, 1'b0, 6'h01, 1'b0));
    chk(16'(st[14]), 16'h0000, "off drivers ignored");
    uld <= 6'h07;
    cyc(ULD + 20);
    chk(16'(hbo), 16'h0001, "no shutdown when disabled");
    fr(ctl(1'b0, 1'b0, 6'h01, 1'b0));
    chk(16'(st[14]), 16'h0001, "ul flag");
    uld <= 6'h00;
    fr(ctl(1'b1, 1'b0, 6'h05, 1'b1));
    uld <= 6'h01;
    cyc(500);
    uld <= 6'h05;
    cyc(ULD - 540);
    chk(16'(hbo), 16'h0005, "before shared expiry");
    cyc(60);
    chk(16'(hbo), 16'h0000, "both latch at shared expiry");
    fr(ctl(1'b1, 1'b0, 6'h05, 1'b0));
    chk(16'(st[14]), 16'h0001, "ul flag kept");
    chk(16'(hbo), 16'h0000, "ul latch kept");
    uld <= 6'h00;
    fr(ctl(1'b0, 1'b0, 6'h05, 1'b1));
    chk(16'(hbo), 16'h0005, "ul released");
    fr(ctl(1'b0, 1'b0, 6'h00, 1'b0));
    chk(16'(st[14]), 16'h0000, "ul flag cleared");
  endtask

  // ==========================================
  // Verdict
  task automatic tally_and_finish;
    if (mismatches == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    overcurrent_delay_select = 6'h00;
    uld = 6'h00;
    ot = 1'b0;
    cyc(3);
    reset_n <= 1'b1;
    cyc(4);
    t_regs();
    t_shoot();
    t_ovc();
    t_temp();
    t_uld();
    tally_and_finish();
  end

  // Watchdog: a clean run takes about 100 us
  initial begin
    #300_000;
    mismatches++;
    tally_and_finish();
  end
endmodule
